// ---- design/output_voltage_setpoint_regs.sv ----
// Setpoint, limit, divider and input level registers of one converter channel.
// Assumes the bus target logic decodes commands and delivers 16-bit words with
// one-cycle read and write strobes, all synchronous to I_CLK.
`timescale 1ns/1ps

// How it works
// - Setpoint is 12 bits, 2 mV steps.
// - Feedback target is the commanded output (selected source after clamping) times divider ratio.
// - Ceiling limits output regardless of selected source.
// - Above ceiling: use ceiling, flag, notify host.
// - Ceiling writes saturate at six volts.
// - Below floor: use floor, flag, notify host.
// - Floor writes saturate up to half volt.
// - Divider ratio is 10 bits, 0.001 steps.
// - Run starts when input reaches turn-on level while startup is ok.
// - Run stops when input falls to turn-off.
module output_voltage_setpoint_regs
(
  input  wire logic                                   I_CLK,
  input  wire logic                                   I_RST_N,
  input  wire logic [7:0]                             I_CMD_CODE,
  input  wire logic                                   I_WR_STB,
  input  wire logic [vout_setpoint_pkg::DATA_W-1:0]   I_WR_DATA,
  input  wire logic                                   I_RD_STB,
  input  wire vout_setpoint_pkg::vout_sel_e           I_VOUT_SEL,
  input  wire logic [vout_setpoint_pkg::VIN_W-1:0]    I_VIN_LEVEL,
  input  wire logic                                   I_STARTUP_OK,
  input  wire logic                                   I_CLEAR_FAULTS,
  output logic      [vout_setpoint_pkg::DATA_W-1:0]   O_RD_DATA,
  output logic                                        O_RD_VALID,
  output logic                                        O_CMD_NACK,
  output logic      [vout_setpoint_pkg::VOUT_W-1:0]   O_VOUT_CMD,
  output logic      [vout_setpoint_pkg::FB_W-1:0]     O_FB_REF,
  output logic                                        O_STATUS_OUTPUT_FLAG,
  output logic                                        O_LIMIT_WARN,
  output logic                                        O_HOST_NOTIFY,
  output logic                                        O_CONV_RUN
);
  import vout_setpoint_pkg::*;

  if (VOUT_W > DATA_W || SCALE_W > DATA_W || VIN_W > DATA_W)
  begin : g_width_check
    $error("Register fields must fit in the data word.");
  end

  // --------------------------------------------------------------------------
  // Register storage
  // --------------------------------------------------------------------------
  logic [VOUT_W-1:0]  setpoint_r;
  logic [VOUT_W-1:0]  setpoint_nxt;
  logic [VOUT_W-1:0]  ceiling_r;
  logic [VOUT_W-1:0]  ceiling_nxt;
  logic [VOUT_W-1:0]  margin_high_r;
  logic [VOUT_W-1:0]  margin_high_nxt;
  logic [VOUT_W-1:0]  margin_low_r;
  logic [VOUT_W-1:0]  margin_low_nxt;
  logic [SCALE_W-1:0] divider_r;
  logic [SCALE_W-1:0] divider_nxt;
  logic [VOUT_W-1:0]  floor_r;
  logic [VOUT_W-1:0]  floor_nxt;
  logic [VIN_W-1:0]   turn_on_r;
  logic [VIN_W-1:0]   turn_on_nxt;
  logic [VIN_W-1:0]   turn_off_r;
  logic [VIN_W-1:0]   turn_off_nxt;

  logic               known_cmd;
  logic               src_write;
  logic [VOUT_W-1:0]  wr_vout;

  assign wr_vout = I_WR_DATA[VOUT_W-1:0];

  always_comb
  begin
    setpoint_nxt    = setpoint_r;
    ceiling_nxt     = ceiling_r;
    margin_high_nxt = margin_high_r;
    margin_low_nxt  = margin_low_r;
    divider_nxt     = divider_r;
    floor_nxt       = floor_r;
    turn_on_nxt     = turn_on_r;
    turn_off_nxt    = turn_off_r;
    known_cmd       = 1'b1;
    case (I_CMD_CODE)
      CMD_OUTPUT_VOLTAGE_SETPOINT:
      begin
        if (I_WR_STB)
        begin
          setpoint_nxt = wr_vout;
        end
      end
      CMD_OUTPUT_VOLTAGE_CEILING:
      begin
        if (I_WR_STB)
        begin
          ceiling_nxt = (wr_vout > CEILING_MAX_CODE) ? CEILING_MAX_CODE : wr_vout;
        end
      end
      CMD_MARGIN_HIGH_SETPOINT:
      begin
        if (I_WR_STB)
        begin
          margin_high_nxt = wr_vout;
        end
      end
      CMD_MARGIN_LOW_SETPOINT:
      begin
        if (I_WR_STB)
        begin
          margin_low_nxt = wr_vout;
        end
      end
      CMD_FEEDBACK_DIVIDER_RATIO:
      begin
        if (I_WR_STB)
        begin
          divider_nxt = I_WR_DATA[SCALE_W-1:0];
        end
      end
      CMD_OUTPUT_VOLTAGE_FLOOR:
      begin
        if (I_WR_STB)
        begin
          floor_nxt = (wr_vout < FLOOR_MIN_CODE) ? FLOOR_MIN_CODE : wr_vout;
        end
      end
      CMD_INPUT_TURN_ON_LEVEL:
      begin
        if (I_WR_STB)
        begin
          turn_on_nxt = I_WR_DATA[VIN_W-1:0];
        end
      end
      CMD_INPUT_TURN_OFF_LEVEL:
      begin
        if (I_WR_STB)
        begin
          turn_off_nxt = I_WR_DATA[VIN_W-1:0];
        end
      end
      default:
      begin
        known_cmd = 1'b0;
      end
    endcase
  end

  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_N)
    begin
      setpoint_r    <= RST_SETPOINT;
      ceiling_r     <= RST_CEILING;
      margin_high_r <= RST_MARGIN_HIGH;
      margin_low_r  <= RST_MARGIN_LOW;
      divider_r     <= RST_DIVIDER;
      floor_r       <= RST_FLOOR;
      turn_on_r     <= RST_TURN_ON;
      turn_off_r    <= RST_TURN_OFF;
    end
    else
    begin
      setpoint_r    <= setpoint_nxt;
      ceiling_r     <= ceiling_nxt;
      margin_high_r <= margin_high_nxt;
      margin_low_r  <= margin_low_nxt;
      divider_r     <= divider_nxt;
      floor_r       <= floor_nxt;
      turn_on_r     <= turn_on_nxt;
      turn_off_r    <= turn_off_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // Read-back
  // --------------------------------------------------------------------------
  logic [DATA_W-1:0] rd_data_r;
  logic [DATA_W-1:0] rd_data_nxt;
  logic              rd_valid_r;
  logic              rd_valid_nxt;
  logic              nack_r;
  logic              nack_nxt;

  always_comb
  begin
    rd_data_nxt  = rd_data_r;
    rd_valid_nxt = I_RD_STB;
    nack_nxt     = (I_RD_STB || I_WR_STB) && !known_cmd;
    if (I_RD_STB)
    begin
      case (I_CMD_CODE)
        CMD_OUTPUT_VOLTAGE_SETPOINT: rd_data_nxt = DATA_W'(setpoint_r);
        CMD_OUTPUT_VOLTAGE_CEILING:  rd_data_nxt = DATA_W'(ceiling_r);
        CMD_MARGIN_HIGH_SETPOINT:    rd_data_nxt = DATA_W'(margin_high_r);
        CMD_MARGIN_LOW_SETPOINT:     rd_data_nxt = DATA_W'(margin_low_r);
        CMD_FEEDBACK_DIVIDER_RATIO:  rd_data_nxt = DATA_W'(divider_r);
        CMD_OUTPUT_VOLTAGE_FLOOR:    rd_data_nxt = DATA_W'(floor_r);
        CMD_INPUT_TURN_ON_LEVEL:     rd_data_nxt = DATA_W'(turn_on_r);
        CMD_INPUT_TURN_OFF_LEVEL:    rd_data_nxt = DATA_W'(turn_off_r);
        default:                     rd_data_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_N)
    begin
      rd_data_r  <= '0;
      rd_valid_r <= 1'b0;
      nack_r     <= 1'b0;
    end
    else
    begin
      rd_data_r  <= rd_data_nxt;
      rd_valid_r <= rd_valid_nxt;
      nack_r     <= nack_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // Source selection and clamping
  // --------------------------------------------------------------------------
  vout_limit_if lim ();

  logic [VOUT_W-1:0] request;

  always_comb
  begin
    case (I_VOUT_SEL)
      SEL_MARGIN_LOW:  request = margin_low_r;
      SEL_MARGIN_HIGH: request = margin_high_r;
      default:         request = setpoint_r;
    endcase
  end

  assign lim.request   = request;
  assign lim.ceiling   = ceiling_r;
  assign lim.floor_lvl = floor_r;

  vout_clamp u_clamp
  (
    .lim (lim.limiter)
  );

  // A new out-of-range request raises the flags; a held one does not repeat.
  always_comb
  begin
    case (I_VOUT_SEL)
      SEL_MARGIN_LOW:  src_write = I_WR_STB && (I_CMD_CODE == CMD_MARGIN_LOW_SETPOINT);
      SEL_MARGIN_HIGH: src_write = I_WR_STB && (I_CMD_CODE == CMD_MARGIN_HIGH_SETPOINT);
      default:         src_write = I_WR_STB && (I_CMD_CODE == CMD_OUTPUT_VOLTAGE_SETPOINT);
    endcase
  end

  // --------------------------------------------------------------------------
  // Commanded output, feedback target and limit flags
  // --------------------------------------------------------------------------
  logic [VOUT_W-1:0] vout_cmd_r;
  logic [VOUT_W-1:0] vout_cmd_nxt;
  logic [FB_W-1:0]   fb_ref_r;
  logic [FB_W-1:0]   fb_ref_nxt;
  logic              clamp_r;
  logic              clamp_nxt;
  logic              pend_r;
  logic              pend_nxt;
  logic              status_flag_r;
  logic              status_flag_nxt;
  logic              warn_r;
  logic              warn_nxt;
  logic              notify_r;
  logic              notify_nxt;
  logic              limit_event;

  always_comb
  begin
    clamp_nxt       = lim.over || lim.under;
    pend_nxt        = src_write;
    limit_event     = clamp_nxt && (!clamp_r || pend_r);
    vout_cmd_nxt    = lim.commanded;
    fb_ref_nxt      = FB_W'(vout_cmd_r) * FB_W'(divider_r);
    status_flag_nxt = limit_event || (status_flag_r && !I_CLEAR_FAULTS);
    warn_nxt        = limit_event || (warn_r && !I_CLEAR_FAULTS);
    notify_nxt      = limit_event;
  end

  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_N)
    begin
      vout_cmd_r    <= RST_SETPOINT;
      fb_ref_r      <= '0;
      clamp_r       <= 1'b0;
      pend_r        <= 1'b0;
      status_flag_r <= 1'b0;
      warn_r        <= 1'b0;
      notify_r      <= 1'b0;
    end
    else
    begin
      vout_cmd_r    <= vout_cmd_nxt;
      fb_ref_r      <= fb_ref_nxt;
      clamp_r       <= clamp_nxt;
      pend_r        <= pend_nxt;
      status_flag_r <= status_flag_nxt;
      warn_r        <= warn_nxt;
      notify_r      <= notify_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // Input level run gate
  // --------------------------------------------------------------------------
  vin_run_gate u_run_gate
  (
    .i_clk        (I_CLK),
    .i_rst_n      (I_RST_N),
    .i_vin_level  (I_VIN_LEVEL),
    .i_turn_on    (turn_on_r),
    .i_turn_off   (turn_off_r),
    .i_startup_ok (I_STARTUP_OK),
    .o_run        (O_CONV_RUN)
  );

  assign O_RD_DATA            = rd_data_r;
  assign O_RD_VALID           = rd_valid_r;
  assign O_CMD_NACK           = nack_r;
  assign O_VOUT_CMD           = vout_cmd_r;
  assign O_FB_REF             = fb_ref_r;
  assign O_STATUS_OUTPUT_FLAG = status_flag_r;
  assign O_LIMIT_WARN         = warn_r;
  assign O_HOST_NOTIFY        = notify_r;

endmodule : output_voltage_setpoint_regs

// ---- design/vout_setpoint_pkg.sv ----
// Constants shared by the output voltage setpoint register bank.
// Assumes one converter channel and 16-bit command data from the target logic.
package vout_setpoint_pkg;

  // --------------------------------------------------------------------------
  // Command codes
  // --------------------------------------------------------------------------
  localparam logic [7:0] CMD_OUTPUT_VOLTAGE_SETPOINT = 8'h21;
  localparam logic [7:0] CMD_OUTPUT_VOLTAGE_CEILING  = 8'h24;
  localparam logic [7:0] CMD_MARGIN_HIGH_SETPOINT    = 8'h25;
  localparam logic [7:0] CMD_MARGIN_LOW_SETPOINT     = 8'h26;
  localparam logic [7:0] CMD_FEEDBACK_DIVIDER_RATIO  = 8'h29;
  localparam logic [7:0] CMD_OUTPUT_VOLTAGE_FLOOR    = 8'h2B;
  localparam logic [7:0] CMD_INPUT_TURN_ON_LEVEL     = 8'h35;
  localparam logic [7:0] CMD_INPUT_TURN_OFF_LEVEL    = 8'h36;

  // --------------------------------------------------------------------------
  // Field widths
  // --------------------------------------------------------------------------
  localparam int DATA_W  = 16;
  localparam int VOUT_W  = 12;
  localparam int SCALE_W = 10;
  localparam int VIN_W   = 6;
  localparam int FB_W    = VOUT_W + SCALE_W;

  // --------------------------------------------------------------------------
  // Scales and limits, in microvolts
  // --------------------------------------------------------------------------
  localparam int VOUT_LSB_UV      = 2000;
  localparam int VIN_LSB_UV       = 250000;
  localparam int CEILING_MAX_UV   = 6000000;
  localparam int FLOOR_MIN_UV     = 500000;
  localparam logic [VOUT_W-1:0] CEILING_MAX_CODE = VOUT_W'(CEILING_MAX_UV / VOUT_LSB_UV);
  localparam logic [VOUT_W-1:0] FLOOR_MIN_CODE   = VOUT_W'(FLOOR_MIN_UV / VOUT_LSB_UV);

  // --------------------------------------------------------------------------
  // Reset values
  // --------------------------------------------------------------------------
  localparam logic [VOUT_W-1:0]  RST_SETPOINT    = 12'h1F4;
  localparam logic [VOUT_W-1:0]  RST_CEILING     = 12'h708;
  localparam logic [VOUT_W-1:0]  RST_MARGIN_HIGH = 12'h226;
  localparam logic [VOUT_W-1:0]  RST_MARGIN_LOW  = 12'h1C2;
  localparam logic [SCALE_W-1:0] RST_DIVIDER     = 10'h3E8;
  localparam logic [VOUT_W-1:0]  RST_FLOOR       = 12'h0FA;
  localparam logic [VIN_W-1:0]   RST_TURN_ON     = 6'h10;
  localparam logic [VIN_W-1:0]   RST_TURN_OFF    = 6'h0E;

  // --------------------------------------------------------------------------
  // Setpoint source selection
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {SEL_NOMINAL, SEL_MARGIN_LOW, SEL_MARGIN_HIGH} vout_sel_e;

endpackage : vout_setpoint_pkg

// ---- design/vout_limit_if.sv ----
// Carries a requested setpoint and its limits to the clamp, and the result back.
// Assumes both ends sit in the same clock domain; the clamp is combinational.
`timescale 1ns/1ps
interface vout_limit_if;
  import vout_setpoint_pkg::*;

  logic [VOUT_W-1:0] request;
  logic [VOUT_W-1:0] ceiling;
  logic [VOUT_W-1:0] floor_lvl;
  logic [VOUT_W-1:0] commanded;
  logic              over;
  logic              under;

  modport requester (output request, ceiling, floor_lvl, input commanded, over, under);
  modport limiter   (input request, ceiling, floor_lvl, output commanded, over, under);

endinterface : vout_limit_if

// ---- design/vout_clamp.sv ----
// Clamps a requested output setpoint between the ceiling and the floor.
// Assumes the floor is not above the ceiling; if it is, requests above the ceiling get the ceiling and all others get the floor.
`timescale 1ns/1ps
module vout_clamp
(
  vout_limit_if.limiter lim
);
  import vout_setpoint_pkg::*;

  always_comb
  begin
    lim.over      = lim.request > lim.ceiling;
    lim.under     = lim.request < lim.floor_lvl;
    lim.commanded = lim.request;
    if (lim.over)
    begin
      lim.commanded = lim.ceiling;
    end
    else if (lim.under)
    begin
      lim.commanded = lim.floor_lvl;
    end
  end

endmodule : vout_clamp

// ---- design/vin_run_gate.sv ----
// Decides whether the converter runs from the input level and its on/off levels.
// Assumes the input level is a synchronous code in the same units as the levels.
`timescale 1ns/1ps
module vin_run_gate
(
  input  wire logic                              i_clk,
  input  wire logic                              i_rst_n,
  input  wire logic [vout_setpoint_pkg::VIN_W-1:0] i_vin_level,
  input  wire logic [vout_setpoint_pkg::VIN_W-1:0] i_turn_on,
  input  wire logic [vout_setpoint_pkg::VIN_W-1:0] i_turn_off,
  input  wire logic                              i_startup_ok,
  output logic                                   o_run
);
  import vout_setpoint_pkg::*;

  logic run_r;
  logic run_nxt;

  always_comb
  begin
    run_nxt = run_r;
    if (!run_r)
    begin
      run_nxt = i_startup_ok && (i_vin_level >= i_turn_on);
    end
    else if ((i_vin_level <= i_turn_off) || !i_startup_ok)
    begin
      run_nxt = 1'b0;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      run_r <= 1'b0;
    end
    else
    begin
      run_r <= run_nxt;
    end
  end

  assign o_run = run_r;

endmodule : vin_run_gate

// ---- sim/vout_regs_sva.sv ----
// Checker for the setpoint register bank, bound to its top module.
// Assumes the command codes and reset values of vout_setpoint_pkg.
`timescale 1ns/1ps
module vout_regs_sva
(
  input wire logic        I_CLK,
  input wire logic        I_RST_N,
  input wire logic [7:0]  I_CMD_CODE,
  input wire logic        I_WR_STB,
  input wire logic [15:0] I_WR_DATA,
  input wire logic        I_STARTUP_OK,
  input wire logic        I_CLEAR_FAULTS,
  input wire logic [15:0] O_RD_DATA,
  input wire logic        O_RD_VALID,
  input wire logic [11:0] O_VOUT_CMD,
  input wire logic [21:0] O_FB_REF,
  input wire logic        O_STATUS_OUTPUT_FLAG,
  input wire logic        O_LIMIT_WARN,
  input wire logic        O_HOST_NOTIFY,
  input wire logic        O_CONV_RUN
);
  import vout_setpoint_pkg::*;

  // ------------
  // Shadow of the ceiling, capped at six volts as the bank stores it, and of the divider as the host wrote it.
  // ------------
  logic [11:0] ceil_r;
  logic [9:0]  div_r;

  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_N)
    begin
      ceil_r <= RST_CEILING;
      div_r  <= RST_DIVIDER;
    end
    else if (I_WR_STB)
    begin
      if (I_CMD_CODE == CMD_OUTPUT_VOLTAGE_CEILING)
        ceil_r <= (I_WR_DATA[11:0] > CEILING_MAX_CODE) ? CEILING_MAX_CODE : I_WR_DATA[11:0];
      if (I_CMD_CODE == CMD_FEEDBACK_DIVIDER_RATIO)
        div_r <= I_WR_DATA[9:0];
    end
  end

  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_RST_N);

  // ------------
  // Assertions
  // ------------
  upper_bits_zero_a: assert property (O_RD_VALID |-> O_RD_DATA[15:12] == 4'h0)
    else $error("upper read bits not zero");
  ceiling_cap_a: assert property (O_VOUT_CMD <= CEILING_MAX_CODE)
    else $error("commanded value above six volts");
  ceiling_hold_a: assert property (O_VOUT_CMD <= $past(ceil_r))
    else $error("commanded value above ceiling");
  fb_product_a: assert property (($stable(O_VOUT_CMD) && $stable(div_r)) [*3]
    |-> O_FB_REF == O_VOUT_CMD * div_r) else $error("feedback target not the product");
  notify_flags_a: assert property (O_HOST_NOTIFY |-> O_STATUS_OUTPUT_FLAG && O_LIMIT_WARN)
    else $error("notify without flags");
  flag_pair_a: assert property (O_STATUS_OUTPUT_FLAG == O_LIMIT_WARN)
    else $error("status flags differ");
  warn_sticky_a: assert property (O_LIMIT_WARN && !I_CLEAR_FAULTS |=> O_LIMIT_WARN)
    else $error("warning dropped without clear");
  warn_notify_a: assert property ($rose(O_LIMIT_WARN) |-> O_HOST_NOTIFY)
    else $error("warning set without notify");
  run_stop_a: assert property (!I_STARTUP_OK |=> !O_CONV_RUN)
    else $error("running without startup ok");
  run_start_a: assert property ($rose(O_CONV_RUN) |-> $past(I_STARTUP_OK))
    else $error("run started without startup ok");

  cover property (O_HOST_NOTIFY);
  cover property ($rose(O_CONV_RUN));
  cover property (O_RD_VALID && O_RD_DATA == 16'h0BB8);
endmodule : vout_regs_sva

bind output_voltage_setpoint_regs vout_regs_sva u_vout_regs_sva
(
  .I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_CMD_CODE(I_CMD_CODE), .I_WR_STB(I_WR_STB),
  .I_WR_DATA(I_WR_DATA), .I_STARTUP_OK(I_STARTUP_OK), .I_CLEAR_FAULTS(I_CLEAR_FAULTS),
  .O_RD_DATA(O_RD_DATA), .O_RD_VALID(O_RD_VALID), .O_VOUT_CMD(O_VOUT_CMD),
  .O_FB_REF(O_FB_REF), .O_STATUS_OUTPUT_FLAG(O_STATUS_OUTPUT_FLAG),
  .O_LIMIT_WARN(O_LIMIT_WARN), .O_HOST_NOTIFY(O_HOST_NOTIFY), .O_CONV_RUN(O_CONV_RUN)
);

// ---- sim/pmbus_host_model.sv ----
// Host side model: issues one-word register reads and writes.
// Assumes the bank takes a strobe at a rising edge and answers one cycle later.
`timescale 1ns/1ps
module pmbus_host_model
(
  input  wire logic        i_clk,
  input  wire logic [15:0] i_rd_data,
  input  wire logic        i_rd_valid,
  input  wire logic        i_cmd_nack,
  output logic      [7:0]  o_cmd_code,
  output logic             o_wr_stb,
  output logic      [15:0] o_wr_data,
  output logic             o_rd_stb
);
  initial
  begin
    o_cmd_code = 8'h00;
    o_wr_stb   = 1'b0;
    o_wr_data  = 16'h0000;
    o_rd_stb   = 1'b0;
  end

  // Released data is inverted so a stale word is never mistaken for a live one.
  task automatic wr(input logic [7:0] code, input logic [15:0] data);
    @(negedge i_clk);
    o_cmd_code = code;
    o_wr_data  = data;
    o_wr_stb   = 1'b1;
    @(negedge i_clk);
    o_wr_stb   = 1'b0;
    o_wr_data  = ~data;
  endtask : wr

  task automatic rd(input logic [7:0] code, output logic [15:0] data, output logic nack);
    @(negedge i_clk);
    o_cmd_code = code;
    o_rd_stb   = 1'b1;
    @(negedge i_clk);
    o_rd_stb   = 1'b0;
    o_cmd_code = ~code;
    data       = (i_rd_valid === 1'b1) ? i_rd_data : 16'hDEAD;
    nack       = i_cmd_nack;
  endtask : rd
endmodule : pmbus_host_model

// ---- sim/output_voltage_setpoint_regs_tb_top.sv ----
// Self-checking bench for the setpoint register bank.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/1ps
module output_voltage_setpoint_regs_tb_top;
  import vout_setpoint_pkg::*;

  logic        clk = 1'b0;
  logic        rst_n;
  logic [7:0]  cmd;
  logic        wr, rd, ok, clr, rvalid, nack, flag, warn, notify, run, n;
  logic [15:0] wdata, rdata, d;
  vout_sel_e   sel;
  logic [5:0]  vin;
  logic [11:0] vcmd;
  logic [21:0] fb;
  int          bad_count = 0;
  int          n_checks = 0;
  logic [7:0]  codes[8] = '{CMD_OUTPUT_VOLTAGE_SETPOINT, CMD_OUTPUT_VOLTAGE_CEILING,
    CMD_MARGIN_HIGH_SETPOINT, CMD_MARGIN_LOW_SETPOINT, CMD_FEEDBACK_DIVIDER_RATIO,
    CMD_OUTPUT_VOLTAGE_FLOOR, CMD_INPUT_TURN_ON_LEVEL, CMD_INPUT_TURN_OFF_LEVEL};
  logic [15:0] rst_v[8] = '{RST_SETPOINT, RST_CEILING, RST_MARGIN_HIGH, RST_MARGIN_LOW,
    RST_DIVIDER, RST_FLOOR, RST_TURN_ON, RST_TURN_OFF};
  logic [15:0] wr_v[8] = '{16'hF2A0, 16'hF700, 16'hF300, 16'hF100, 16'hFFFF, 16'hF0FB,
    16'hFFFF, 16'hFFC5};
  logic [15:0] mask[8] = '{16'h0FFF, 16'h0FFF, 16'h0FFF, 16'h0FFF, 16'h03FF, 16'h0FFF,
    16'h003F, 16'h003F};

  always #5 clk = ~clk;

  pmbus_host_model u_pmbus_host_model
  (
    .i_clk(clk), .i_rd_data(rdata), .i_rd_valid(rvalid), .i_cmd_nack(nack),
    .o_cmd_code(cmd), .o_wr_stb(wr), .o_wr_data(wdata), .o_rd_stb(rd)
  );

  output_voltage_setpoint_regs u_output_voltage_setpoint_regs
  (
    .I_CLK(clk), .I_RST_N(rst_n), .I_CMD_CODE(cmd), .I_WR_STB(wr), .I_WR_DATA(wdata),
    .I_RD_STB(rd), .I_VOUT_SEL(sel), .I_VIN_LEVEL(vin), .I_STARTUP_OK(ok),
    .I_CLEAR_FAULTS(clr), .O_RD_DATA(rdata), .O_RD_VALID(rvalid), .O_CMD_NACK(nack),
    .O_VOUT_CMD(vcmd), .O_FB_REF(fb), .O_STATUS_OUTPUT_FLAG(flag), .O_LIMIT_WARN(warn),
    .O_HOST_NOTIFY(notify), .O_CONV_RUN(run)
  );

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e)
    begin
      bad_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, s, e);
    end
  endtask : chk

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : wrap_up

  // Brings the nominal setpoint back in range, then clears the sticky flags.
  task automatic restore();
    u_pmbus_host_model.wr(CMD_OUTPUT_VOLTAGE_SETPOINT, 16'h0200);
    repeat (2) @(negedge clk);
    clr = 1'b1;
    @(negedge clk);
    clr = 1'b0;
    @(negedge clk);
    chk(warn, 1'b0);
  endtask : restore

  task automatic t_reset();
    chk(vcmd, RST_SETPOINT);
    foreach (codes[i])
    begin
      u_pmbus_host_model.rd(codes[i], d, n);
      chk(d, rst_v[i]);
    end
  endtask : t_reset

  // Divider and input levels written here are mask test patterns; t_run writes the input levels again.
  task automatic t_mask();
    foreach (codes[i])
    begin
      u_pmbus_host_model.wr(codes[i], wr_v[i]);
      u_pmbus_host_model.rd(codes[i], d, n);
      chk(d, wr_v[i] & mask[i]);
    end
    repeat (3) @(negedge clk);
    chk(vcmd, 12'h2A0);
    chk(fb, 22'h2A0 * 22'h3FF);
  endtask : t_mask

  task automatic t_sat();
    u_pmbus_host_model.wr(CMD_OUTPUT_VOLTAGE_CEILING, 16'h0FFF);
    u_pmbus_host_model.rd(CMD_OUTPUT_VOLTAGE_CEILING, d, n);
    chk(d, CEILING_MAX_CODE);
    u_pmbus_host_model.wr(CMD_OUTPUT_VOLTAGE_FLOOR, 16'h0001);
    u_pmbus_host_model.rd(CMD_OUTPUT_VOLTAGE_FLOOR, d, n);
    chk(d, FLOOR_MIN_CODE);
    u_pmbus_host_model.rd(8'h22, d, n);
    chk(n, 1'b1);
    u_pmbus_host_model.wr(CMD_OUTPUT_VOLTAGE_CEILING, 16'h0700);
  endtask : t_sat

  task automatic t_high();
    u_pmbus_host_model.wr(CMD_OUTPUT_VOLTAGE_SETPOINT, 16'h0800);
    @(negedge clk);
    chk(notify, 1'b1);
    chk(vcmd, 12'h700);
    chk(flag, 1'b1);
    @(negedge clk);
    chk(notify, 1'b0);
    u_pmbus_host_model.wr(CMD_OUTPUT_VOLTAGE_SETPOINT, 16'h0800);
    @(negedge clk);
    chk(notify, 1'b1);
    restore();
  endtask : t_high

  task automatic t_low();
    u_pmbus_host_model.wr(CMD_OUTPUT_VOLTAGE_SETPOINT, 16'h0050);
    @(negedge clk);
    chk(vcmd, FLOOR_MIN_CODE);
    chk(notify & warn & flag, 1'b1);
    restore();
  endtask : t_low

  task automatic t_margin();
    sel = SEL_MARGIN_HIGH;
    repeat (3) @(negedge clk);
    chk(vcmd, 12'h300);
    u_pmbus_host_model.wr(CMD_MARGIN_HIGH_SETPOINT, 16'h0900);
    @(negedge clk);
    chk(vcmd, 12'h700);
    chk(notify, 1'b1);
    sel = SEL_MARGIN_LOW;
    u_pmbus_host_model.wr(CMD_MARGIN_LOW_SETPOINT, 16'h0020);
    @(negedge clk);
    chk(vcmd, FLOOR_MIN_CODE);
    chk(notify, 1'b1);
    sel = SEL_NOMINAL;
    restore();
  endtask : t_margin

  task automatic t_run();
    u_pmbus_host_model.wr(CMD_INPUT_TURN_ON_LEVEL, 16'h0010);
    u_pmbus_host_model.wr(CMD_INPUT_TURN_OFF_LEVEL, 16'h000E);
    ok = 1'b1;
    vin = 6'h0F;
    repeat (2) @(negedge clk);
    chk(run, 1'b0);
    vin = 6'h10;
    @(negedge clk);
    chk(run, 1'b1);
    vin = 6'h0F;
    @(negedge clk);
    chk(run, 1'b1);
    vin = 6'h0E;
    @(negedge clk);
    chk(run, 1'b0);
    vin = 6'h10;
    @(negedge clk);
    ok = 1'b0;
    @(negedge clk);
    chk(run, 1'b0);
  endtask : t_run

  initial
  begin
    rst_n = 1'b0;
    sel = SEL_NOMINAL;
    vin = 6'h00;
    ok = 1'b0;
    clr = 1'b0;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    t_reset();
    t_mask();
    t_sat();
    t_high();
    t_low();
    t_margin();
    t_run();
    wrap_up();
  end

  initial
  begin
    #100000;
    bad_count++;
    wrap_up();
  end
endmodule : output_voltage_setpoint_regs_tb_top
